// [rtl/pcfr_regs.sv]
// parallel cable framing register bank with its fifos, line setup and frame logic
`timescale 1ns/1ps

module pcfr_fifo (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // control
  input  wire logic                 clr,
  input  wire logic [31:0]          thr,
  // write side
  input  wire logic                 push,
  input  wire logic [31:0]          wdata,
  // read side
  input  wire logic                 pop,
  output logic      [31:0]          rdata,
  output pcfr_pkg::pcfr_flags_t     flags
);
  pcfr_pkg::pcfr_fifo_st_t q;
  pcfr_pkg::pcfr_fifo_st_t d;
  logic                    do_push;
  logic                    do_pop;
  logic [5:0]              free;

  always_comb begin
    d       = q;
    do_push = push && (q.cnt != pcfr_pkg::FIFO_FULL);
    do_pop  = pop && (q.cnt != 6'h00);
    free    = pcfr_pkg::FIFO_FULL - q.cnt;
    if (clr) begin
      d.wp  = 5'h00;
      d.rp  = 5'h00;
      d.cnt = 6'h00;
      d.ae  = thr[15:0];
      d.af  = thr[31:16];
    end else begin
      if (do_push) begin
        d.mem[q.wp] = wdata;
        d.wp        = q.wp + 5'h01;
      end
      if (do_pop) begin
        d.rp = q.rp + 5'h01;
      end
      d.cnt = q.cnt + {5'h00, do_push} - {5'h00, do_pop};
    end
    rdata        = q.mem[q.rp];
    flags.empty  = (q.cnt == 6'h00);
    flags.full   = (q.cnt == pcfr_pkg::FIFO_FULL);
    flags.aempty = ({10'h000, q.cnt} <= q.ae);
    // flag asserts once free words minus one falls to the level
    flags.afull  = ({11'h000, free} <= ({1'b0, q.af} + 17'h00001));
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q     <= '0;
      q.ae  <= pcfr_pkg::THR_RST[15:0];
      q.af  <= pcfr_pkg::THR_RST[31:16];
    end else begin
      q <= d;
    end
  end
endmodule

module pcfr_regs (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // register port
  input  wire pcfr_pkg::pcfr_bus_t  bus_req,
  output logic      [31:0]          bus_rdata,
  // cable command lines
  input  wire logic [6:0]           cable_line_i,
  output logic      [6:0]           cable_line_o,
  output logic      [6:0]           cable_line_oe,
  // cable data
  output logic      [31:0]          cable_tx_data,
  output logic                      cable_tx_clk,
  input  wire logic                 cable_rx_clk,
  input  wire logic [31:0]          cable_rx_data,
  // board straps
  input  wire logic [1:0]           board_jumper,
  input  wire logic                 xcvr_pecl
);
  typedef struct packed {
    logic [pcfr_pkg::SY_W-1:0] s1;
    logic [pcfr_pkg::SY_W-1:0] s2;
    logic                      rxclk_d;
    logic                      rx_fv_d;
    logic [31:0]               ctrl;
    logic [31:0]               txthr;
    logic [31:0]               rxthr;
    logic [31:0]               stlen;
    logic [31:0]               onlen;
    logic [15:0]               offlen;
    logic [31:0]               rxst;
    logic [31:0]               rxln;
    logic                      ovr_tx;
    logic                      und_rx;
    logic                      ovr_rx;
    pcfr_pkg::pcfr_tx_st_t     tx_st;
    logic [31:0]               tx_cnt;
    logic                      phase;
    logic                      fv;
    logic                      lv;
    logic                      sv;
    logic [31:0]               txdata;
    logic [6:0]                ln_o;
    logic [6:0]                ln_oe;
    logic [31:0]               rdata;
  } pcfr_st_t;

  pcfr_st_t              q;
  pcfr_st_t              d;
  pcfr_pkg::pcfr_flags_t txf;
  pcfr_pkg::pcfr_flags_t rxf;
  logic [31:0]           tx_head;
  logic [31:0]           rx_head;
  logic                  tx_fclr;
  logic                  rx_fclr;
  logic                  tx_push;
  logic                  tx_pop;
  logic                  rx_push;
  logic                  rx_pop;
  logic                  wr_ctl;
  logic                  wr_st;
  logic                  rd_dat;
  logic [6:0]            lfunc;
  logic [6:0]            lout;
  logic [6:0]            lhi;
  logic [6:0]            fn_o;
  logic [6:0]            fn_oe;
  logic [6:0]            lvl;
  logic                  xcvr;
  logic                  rx_rise;
  logic                  rfv;
  logic                  rlv;
  logic                  rsv;
  logic                  word;
  logic                  step;
  pcfr_pkg::pcfr_tx_st_t nst;
  logic                  lv_use;
  logic                  sv_use;

  // {function, output, level}; pair merges the partner's bits on the differential build
  function automatic logic [2:0] line_mode(input logic lo, input logic hi,
                                           input logic plo, input logic phi,
                                           input logic pair);
    logic [2:0] r;
    r = {!lo && !hi, lo, hi};
    if (pair) begin
      r = {!lo && !hi && !plo && !phi, lo && plo, hi};
    end
    return r;
  endfunction

  // entry count of a phase; a zero line-on length still lasts one transmit clock, a zero status or off length skips its phase
  function automatic logic [31:0] len_m1(input logic [31:0] len);
    return (len == 32'h00000000) ? 32'h00000000 : len - 32'h00000001;
  endfunction

  pcfr_fifo u_txf (
    .clock (clock),
    .rst_n (rst_n),
    .clr   (tx_fclr),
    .thr   (q.txthr),
    .push  (tx_push),
    .wdata (bus_req.wdata),
    .pop   (tx_pop),
    .rdata (tx_head),
    .flags (txf)
  );

  pcfr_fifo u_rxf (
    .clock (clock),
    .rst_n (rst_n),
    .clr   (rx_fclr),
    .thr   (q.rxthr),
    .push  (rx_push),
    .wdata (q.s2[pcfr_pkg::SY_DATA +: 32]),
    .pop   (rx_pop),
    .rdata (rx_head),
    .flags (rxf)
  );

  always_comb begin
    d       = q;
    d.s1    = {cable_rx_clk, cable_rx_data, cable_line_i, board_jumper, xcvr_pecl};
    d.s2    = q.s1;
    xcvr    = q.s2[pcfr_pkg::SY_XCVR];
    wr_ctl  = bus_req.wr && (bus_req.addr == pcfr_pkg::OFS_CTRL);
    wr_st   = bus_req.wr && (bus_req.addr == pcfr_pkg::OFS_STATUS);
    rd_dat  = bus_req.rd && (bus_req.addr == pcfr_pkg::OFS_DATA);
    tx_fclr = wr_ctl && bus_req.wdata[pcfr_pkg::CTL_TXFRST];
    rx_fclr = wr_ctl && bus_req.wdata[pcfr_pkg::CTL_RXFRST];
    tx_push = bus_req.wr && (bus_req.addr == pcfr_pkg::OFS_DATA);
    rx_pop  = rd_dat;
    tx_pop  = 1'b0;
    rx_push = 1'b0;
    // line setup decode
    for (int i = 0; i < 7; i++) begin
      {lfunc[i], lout[i], lhi[i]} = line_mode(q.ctrl[pcfr_pkg::CTL_SEL_LO + i],
                                              q.ctrl[pcfr_pkg::CTL_SEL_HI + i],
                                              q.ctrl[pcfr_pkg::CTL_SEL_LO + ((i > 0) ? i - 1 : 0)],
                                              q.ctrl[pcfr_pkg::CTL_SEL_HI + ((i > 0) ? i - 1 : 0)],
                                              xcvr && (i == 2 || i == 4 || i == 6));
    end
    lv_use = lfunc[pcfr_pkg::LN_LINE];
    sv_use = lfunc[pcfr_pkg::LN_STAT];
    fn_o   = {q.ctrl[pcfr_pkg::CTL_RXEN], q.ctrl[pcfr_pkg::CTL_TXEN], !txf.empty,
              !rxf.afull, q.sv, q.lv, q.fv};
    // receiver-ready follows receive enable; data ready and frame lines follow transmit enable
    fn_oe  = {{2{!q.ctrl[pcfr_pkg::CTL_TEST]}}, q.ctrl[pcfr_pkg::CTL_TXEN],
              q.ctrl[pcfr_pkg::CTL_RXEN], {3{q.ctrl[pcfr_pkg::CTL_TXEN]}}};
    for (int i = 0; i < 7; i++) begin
      d.ln_o[i]  = lfunc[i] ? fn_o[i] : lhi[i];
      d.ln_oe[i] = lfunc[i] ? fn_oe[i] : lout[i];
      lvl[i]     = q.ln_oe[i] ? q.ln_o[i] : q.s2[pcfr_pkg::SY_LINE + i];
    end
    // test mode keeps both enable lines quiet in every setting
    if (q.ctrl[pcfr_pkg::CTL_TEST]) begin
      d.ln_oe[6:5] = 2'b00;
    end
    // receive side on sampled link clock edges; data lags the clock by the same two stages
    rx_rise   = q.s2[pcfr_pkg::SY_RXCLK] && !q.rxclk_d;
    d.rxclk_d = q.s2[pcfr_pkg::SY_RXCLK];
    rfv  = lfunc[pcfr_pkg::LN_FRAME] ? q.s2[pcfr_pkg::SY_LINE + pcfr_pkg::LN_FRAME] : 1'b1;
    rlv  = lv_use ? q.s2[pcfr_pkg::SY_LINE + pcfr_pkg::LN_LINE] : 1'b1;
    rsv  = sv_use && q.s2[pcfr_pkg::SY_LINE + pcfr_pkg::LN_STAT];
    word = rfv && (rlv || rsv);
    // frame start taken from the line level: the peer may stop its clock between frames
    d.rx_fv_d = rfv;
    if (rfv && !q.rx_fv_d && q.ctrl[pcfr_pkg::CTL_RXEN] && !q.ctrl[pcfr_pkg::CTL_TXEN]) begin
      if (sv_use) begin
        d.rxst = 32'h00000000;
      end
      if (lv_use) begin
        d.rxln = 32'h00000000;
      end
    end
    if (rx_rise && q.ctrl[pcfr_pkg::CTL_RXEN] && !q.ctrl[pcfr_pkg::CTL_TXEN]) begin
      rx_push = word;
      if (sv_use) begin
        d.rxst = d.rxst + {31'h00000000, rsv && rfv};
      end else begin
        d.rxst = d.rxst + {31'h00000000, word};
      end
      if (lv_use) begin
        d.rxln = d.rxln + {31'h00000000, rfv && rlv};
      end
    end
    if (!q.ctrl[pcfr_pkg::CTL_RXEN] && !sv_use) begin
      d.rxst = 32'h00000000;
    end
    // transmit framing, one transmit clock per two board clocks
    d.phase = !q.phase;
    step    = q.phase;
    nst     = q.tx_st;
    if (step) begin
      case (q.tx_st)
        pcfr_pkg::PCFR_TX_IDLE: begin
          if (q.ctrl[pcfr_pkg::CTL_START] && q.ctrl[pcfr_pkg::CTL_TXEN] && !txf.empty) begin
            nst = (sv_use && q.stlen != 32'h00000000) ? pcfr_pkg::PCFR_TX_STAT :
                  (lv_use && q.offlen != 16'h0000) ? pcfr_pkg::PCFR_TX_LOFF :
                  pcfr_pkg::PCFR_TX_LON;
          end
        end
        pcfr_pkg::PCFR_TX_STAT: begin
          if (q.tx_cnt == 32'h00000000) begin
            nst = (lv_use && q.offlen != 16'h0000) ? pcfr_pkg::PCFR_TX_LOFF :
                  pcfr_pkg::PCFR_TX_LON;
          end
        end
        pcfr_pkg::PCFR_TX_LOFF: begin
          if (q.tx_cnt == 32'h00000000) begin
            nst = pcfr_pkg::PCFR_TX_LON;
          end
        end
        pcfr_pkg::PCFR_TX_LON: begin
          if (q.tx_cnt == 32'h00000000 && lv_use && q.offlen != 16'h0000) begin
            nst = pcfr_pkg::PCFR_TX_LOFF;
          end
        end
        default: nst = pcfr_pkg::PCFR_TX_IDLE;
      endcase
      d.tx_cnt = q.tx_cnt - 32'h00000001;
      if (nst != q.tx_st) begin
        case (nst)
          pcfr_pkg::PCFR_TX_STAT: d.tx_cnt = len_m1(q.stlen);
          pcfr_pkg::PCFR_TX_LOFF: d.tx_cnt = len_m1({16'h0000, q.offlen});
          pcfr_pkg::PCFR_TX_LON:  d.tx_cnt = len_m1(q.onlen);
          default:                d.tx_cnt = 32'h00000000;
        endcase
      end
      d.tx_st = nst;
      d.fv    = (nst != pcfr_pkg::PCFR_TX_IDLE);
      d.sv    = (nst == pcfr_pkg::PCFR_TX_STAT);
      d.lv    = (nst == pcfr_pkg::PCFR_TX_LON) && lv_use;
      if (nst == pcfr_pkg::PCFR_TX_STAT || nst == pcfr_pkg::PCFR_TX_LON) begin
        if (txf.empty || !q.ctrl[pcfr_pkg::CTL_TXEN]) begin
          // frame closes on the first word slot with nothing left to send
          d.tx_st = pcfr_pkg::PCFR_TX_IDLE;
          d.fv    = 1'b0;
          d.sv    = 1'b0;
          d.lv    = 1'b0;
          d.ctrl[pcfr_pkg::CTL_START] = 1'b0;
        end else begin
          tx_pop   = 1'b1;
          d.txdata = tx_head;
        end
      end
    end
    if (q.tx_st == pcfr_pkg::PCFR_TX_IDLE && txf.empty) begin
      d.ctrl[pcfr_pkg::CTL_START] = 1'b0;
    end
    // software side; a write in the same cycle as a clear wins
    if (wr_ctl) begin
      d.ctrl = bus_req.wdata & pcfr_pkg::CTRL_MASK;
    end
    if (bus_req.wr) begin
      case (bus_req.addr)
        pcfr_pkg::OFS_TXTHR:  d.txthr  = bus_req.wdata;
        pcfr_pkg::OFS_RXTHR:  d.rxthr  = bus_req.wdata;
        pcfr_pkg::OFS_STLEN:  d.stlen  = bus_req.wdata;
        pcfr_pkg::OFS_ONLEN:  d.onlen  = bus_req.wdata;
        pcfr_pkg::OFS_OFFLEN: d.offlen = bus_req.wdata[15:0];
        default:              d.offlen = d.offlen;
      endcase
    end
    // sticky error bits, set beats clear
    if (wr_st && bus_req.wdata[pcfr_pkg::ST_TXOVR]) d.ovr_tx = 1'b0;
    if (wr_st && bus_req.wdata[pcfr_pkg::ST_RXUND]) d.und_rx = 1'b0;
    if (wr_st && bus_req.wdata[pcfr_pkg::ST_RXOVR]) d.ovr_rx = 1'b0;
    if (tx_push && txf.full) d.ovr_tx = 1'b1;
    if (rd_dat && rxf.empty) d.und_rx = 1'b1;
    if (rx_push && rxf.full) d.ovr_rx = 1'b1;
    d.rdata = 32'h00000000;
    if (bus_req.rd) begin
      case (bus_req.addr)
        pcfr_pkg::OFS_CTRL:   d.rdata = q.ctrl;
        pcfr_pkg::OFS_STATUS: d.rdata = {8'h00, q.ovr_rx, q.und_rx, q.ovr_tx, 2'b00,
                                         xcvr, q.s2[pcfr_pkg::SY_JMP +: 2],
                                         ~rxf, ~txf, q.ctrl[pcfr_pkg::CTL_START], lvl};
        pcfr_pkg::OFS_TXTHR:  d.rdata = q.txthr;
        pcfr_pkg::OFS_RXTHR:  d.rdata = q.rxthr;
        pcfr_pkg::OFS_FEAT:   d.rdata = pcfr_pkg::FEAT_VAL;
        pcfr_pkg::OFS_DATA:   d.rdata = rx_head;
        pcfr_pkg::OFS_STLEN:  d.rdata = q.stlen;
        pcfr_pkg::OFS_ONLEN:  d.rdata = q.onlen;
        pcfr_pkg::OFS_OFFLEN: d.rdata = {16'h0000, q.offlen};
        pcfr_pkg::OFS_RXST:   d.rdata = q.rxst;
        pcfr_pkg::OFS_RXLN:   d.rdata = q.rxln;
        default:              d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q       <= '0;
      q.ctrl  <= pcfr_pkg::CTRL_RST;
      q.txthr <= pcfr_pkg::THR_RST;
      q.rxthr <= pcfr_pkg::THR_RST;
      q.tx_st <= pcfr_pkg::PCFR_TX_IDLE;
    end else begin
      q <= d;
    end
  end

  assign bus_rdata     = q.rdata;
  assign cable_line_o  = q.ln_o;
  assign cable_line_oe = q.ln_oe;
  assign cable_tx_data = q.txdata;
  assign cable_tx_clk  = q.phase;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_TXOVR_SET: assert property (tx_push && txf.full |=> q.ovr_tx)
    else $error("tx overrun not latched");
  AST_TXOVR_HOLD: assert property (q.ovr_tx && !wr_st |=> q.ovr_tx)
    else $error("tx overrun lost without clear");
  AST_RXUND_SET: assert property (rd_dat && rxf.empty |=> q.und_rx)
    else $error("rx underrun not latched");
  AST_BUSY_READ: assert property (bus_req.rd && bus_req.addr == pcfr_pkg::OFS_STATUS |=>
                                  bus_rdata[7] == $past(q.ctrl[pcfr_pkg::CTL_START]))
    else $error("busy bit wrong");
  AST_FEAT_READ: assert property (bus_req.rd && bus_req.addr == pcfr_pkg::OFS_FEAT |=>
                                  bus_rdata == 32'h0000003F)
    else $error("feature flags wrong");
  AST_TEST_QUIET: assert property (q.ctrl[pcfr_pkg::CTL_TEST] |=>
                                   cable_line_oe[6:5] == 2'b00)
    else $error("enable lines driven in test mode");
  AST_FRAME_END: assert property ($fell(q.fv) |-> !q.ctrl[pcfr_pkg::CTL_START] ||
                                  $past(wr_ctl))
    else $error("start not cleared at frame end");
  AST_FRAME_START: assert property ($rose(q.fv) |-> $past(q.ctrl[pcfr_pkg::CTL_START]))
    else $error("frame began without start");
  AST_L3_OUT: assert property (q.ctrl[19] |=> cable_line_oe[3] &&
                               cable_line_o[3] == $past(q.ctrl[27]))
    else $error("line 3 discrete output wrong");
  AST_L4_OUT: assert property (xcvr && q.ctrl[19] && q.ctrl[20] |=> cable_line_oe[4] &&
                               cable_line_o[4] == $past(q.ctrl[28]))
    else $error("line 4 discrete output wrong");
  AST_STAT_FIRST: assert property ($rose(q.sv) |-> $rose(q.fv) && !q.lv)
    else $error("status phase not at frame start");

  COV_TX_FRAME: cover property ($rose(q.fv) ##[1:200] $fell(q.fv));
  COV_LINE_ALT: cover property ($fell(q.lv) ##[1:200] $rose(q.lv));
  COV_RX_WORD:  cover property (rx_push && !rxf.full);
  COV_RX_OVR:   cover property ($rose(q.ovr_rx));
endmodule

// [shared/pcfr_pkg.sv]
// constants, types and register map of the parallel cable framing register bank
package pcfr_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_TXTHR    = 8'h0C;
  localparam logic [7:0]  OFS_RXTHR    = 8'h10;
  localparam logic [7:0]  OFS_FEAT     = 8'h14;
  localparam logic [7:0]  OFS_DATA     = 8'h18;
  localparam logic [7:0]  OFS_STLEN    = 8'h1C;
  localparam logic [7:0]  OFS_ONLEN    = 8'h20;
  localparam logic [7:0]  OFS_OFFLEN   = 8'h24;
  localparam logic [7:0]  OFS_RXST     = 8'h28;
  localparam logic [7:0]  OFS_RXLN     = 8'h2C;
  // reset and fixed values
  localparam logic [31:0] THR_RST      = 32'h0010000F;
  localparam logic [31:0] CTRL_RST     = 32'h00000000;
  localparam logic [31:0] FEAT_VAL     = 32'h0000003F;
  localparam logic [31:0] CTRL_MASK    = 32'hFFFF01F0;
  // control field positions
  localparam int          CTL_TXFRST   = 1;
  localparam int          CTL_RXFRST   = 2;
  localparam int          CTL_TXEN     = 4;
  localparam int          CTL_RXEN     = 5;
  localparam int          CTL_START    = 8;
  localparam int          CTL_SEL_LO   = 16;
  localparam int          CTL_SEL_HI   = 24;
  localparam int          CTL_TEST     = 31;
  // status field positions
  localparam int          ST_TXOVR     = 21;
  localparam int          ST_RXUND     = 22;
  localparam int          ST_RXOVR     = 23;
  // cable line numbers with a function
  localparam int          LN_FRAME     = 0;
  localparam int          LN_LINE      = 1;
  localparam int          LN_STAT      = 2;
  // synchroniser vector layout
  localparam int          SY_W         = 43;
  localparam int          SY_RXCLK     = 42;
  localparam int          SY_DATA      = 10;
  localparam int          SY_LINE      = 3;
  localparam int          SY_JMP       = 1;
  localparam int          SY_XCVR      = 0;
  // fifo geometry
  localparam int          FIFO_DEPTH   = 32;
  localparam logic [5:0]  FIFO_FULL    = 6'h20;

  typedef enum logic [1:0] {
    PCFR_TX_IDLE = 2'b00,
    PCFR_TX_STAT = 2'b01,
    PCFR_TX_LOFF = 2'b10,
    PCFR_TX_LON  = 2'b11
  } pcfr_tx_st_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pcfr_bus_t;

  typedef struct packed {
    logic full;
    logic afull;
    logic aempty;
    logic empty;
  } pcfr_flags_t;

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][31:0] mem;
    logic [4:0]                  wp;
    logic [4:0]                  rp;
    logic [5:0]                  cnt;
    logic [15:0]                 ae;
    logic [15:0]                 af;
  } pcfr_fifo_st_t;
endpackage

// [tb/pcfr_peer.sv]
// peer board model that sends receive frames onto the cable
`timescale 1ns/1ps
module pcfr_peer (
  // cable toward the device
  output logic        rx_clk,
  output logic [31:0] rx_data,
  output logic [6:0]  lines,
  // discrete levels for lines 3 to 6
  input  wire  [3:0]  gpio
);
  logic [2:0] fls = 3'h0;
  initial begin
    rx_clk = 1'b0;
    rx_data = 32'h0;
  end
  assign lines = {gpio, fls};
  // clock stands still between frames; stale data is inverted so it cannot pass
  task automatic send(input int ns, input int nl, input logic [31:0] base);
    for (int k = 0; k < ns + nl; k++) begin
      fls = (k < ns) ? 3'b101 : 3'b011;
      rx_data = base + 32'(k);
      #160 rx_clk = 1'b1;
      #160 rx_clk = 1'b0;
    end
    fls = 3'b000;
    rx_data = ~rx_data;
  endtask
endmodule

// [tb/pcfr_regs_tb_top.sv]
// bench for the parallel cable framing register bank
`timescale 1ns/1ps
module pcfr_regs_tb_top;
  logic                clock = 1'b0;
  logic                rst_n = 1'b0;
  pcfr_pkg::pcfr_bus_t bus_req = '0;
  logic [31:0]         bus_rdata;
  logic [6:0]          ln_o;
  logic [6:0]          ln_oe;
  logic [6:0]          peer_ln;
  logic [6:0]          ln_w;
  logic                rx_clk;
  logic [31:0]         rx_data;
  logic [31:0]         tx_data;
  logic                tx_clk;
  logic                txc_q = 1'b0;
  logic [31:0]         tx_first = '1;
  int                  err_total = 0;
  int                  samples_checked = 0;
  int                  sv_n = 0;
  int                  lv_n = 0;
  int                  cyc = 0;
  // device drive wins a clash, otherwise the peer's level
  assign ln_w = (ln_oe & ln_o) | (~ln_oe & peer_ln);
  pcfr_regs pcfr_regs_i (
    .clock         (clock),
    .rst_n         (rst_n),
    .bus_req       (bus_req),
    .bus_rdata     (bus_rdata),
    .cable_line_i  (ln_w),
    .cable_line_o  (ln_o),
    .cable_line_oe (ln_oe),
    .cable_tx_data (tx_data),
    .cable_tx_clk  (tx_clk),
    .cable_rx_clk  (rx_clk),
    .cable_rx_data (rx_data),
    .board_jumper  (2'b10),
    .xcvr_pecl     (1'b1)
  );
  pcfr_peer pcfr_peer_i (
    .rx_clk  (rx_clk),
    .rx_data (rx_data),
    .lines   (peer_ln),
    .gpio    (4'hA)
  );
  initial begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    sv_n <= sv_n + int'(ln_oe[2] & ln_o[2]);
    lv_n <= lv_n + int'(ln_oe[1] & ln_o[1]);
    txc_q <= tx_clk;
    // first status word of the frame is on the data lines while status-valid first shows
    if (ln_oe[2] && ln_o[2] && sv_n == 0) tx_first <= tx_data;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clock);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 chk(bus_rdata & m, exp);
  endtask
  task automatic wait_fv(input logic v);
    for (int i = 0; i < 500 && ln_w[0] !== v; i++) @(posedge clock);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h0C, '1, 32'h0010000F);
    rd(8'h10, '1, 32'h0010000F);
    rd(8'h14, '1, 32'h0000003F);
    rd(8'h30, '1, 32'h0);
    rd(8'h08, 32'h0007FF80, 32'h0006CC00);
    $display("reset values done");
    wr(8'h04, 32'h58780000);
    rd(8'h08, 32'h78, 32'h58);
    chk(32'({ln_oe[6:3], ln_o[6:3]}), 32'hFB);
    wr(8'h04, 32'h68000000);
    // released lines reach status only after the two input stages
    repeat (3) @(posedge clock);
    rd(8'h08, 32'h7F, 32'h50);
    chk(32'(ln_oe), 32'h0);
    wr(8'h04, 32'h0);
    rd(8'h04, '1, 32'h0);
    chk(32'(ln_oe[6:5]), 32'h3);
    wr(8'h04, 32'h80000000);
    rd(8'h04, '1, 32'h80000000);
    chk(32'(ln_oe[6:5]), 32'h0);
    $display("line setup done");
    for (int k = 0; k < 3; k++) wr(8'h18, 32'(k));
    rd(8'h08, 32'h300, 32'h100);
    wr(8'h0C, 32'h00000002);
    rd(8'h0C, '1, 32'h00000002);
    rd(8'h08, 32'h200, 32'h0);
    wr(8'h04, 32'h2);
    rd(8'h08, 32'h300, 32'h0);
    for (int k = 0; k < 30; k++) wr(8'h18, 32'(k));
    rd(8'h08, 32'hF00, 32'hF00);
    wr(8'h18, 32'd30);
    rd(8'h08, 32'hC00, 32'h800);
    wr(8'h18, 32'd31);
    wr(8'h18, 32'hDEAD0000);
    rd(8'h08, 32'h200C00, 32'h200000);
    wr(8'h08, 32'h200000);
    rd(8'h08, 32'h200000, 32'h0);
    $display("fifo flags done");
    wr(8'h1C, 32'h1);
    wr(8'h20, 32'h2);
    wr(8'h24, 32'h00010001);
    rd(8'h24, '1, 32'h1);
    sv_n = 0;
    lv_n = 0;
    wr(8'h04, 32'h110);
    wait_fv(1'b1);
    wait_fv(1'b0);
    rd(8'h08, 32'h181, 32'h0);
    chk(32'(sv_n), 32'd2);
    chk(32'(lv_n), 32'd62);
    chk(tx_first, 32'h00000000);
    chk(tx_data, 32'h0000001F);
    @(posedge clock);
    #1 chk(32'(tx_clk ^ txc_q), 32'h1);
    $display("transmit done");
    wr(8'h04, 32'h20);
    pcfr_peer_i.send(2, 3, 32'hA5A50000);
    repeat (8) @(posedge clock);
    rd(8'h28, '1, 32'd2);
    rd(8'h2C, '1, 32'd3);
    for (int k = 0; k < 5; k++) rd(8'h18, '1, 32'hA5A50000 + 32'(k));
    rd(8'h18, 32'h0, 32'h0);
    rd(8'h08, 32'h401000, 32'h400000);
    wr(8'h08, 32'h400000);
    rd(8'h08, 32'h400000, 32'h0);
    pcfr_peer_i.send(1, 0, 32'h5A5A0000);
    repeat (8) @(posedge clock);
    rd(8'h28, '1, 32'd1);
    rd(8'h2C, '1, 32'd0);
    wr(8'h06 - 8'h02, 32'h06000000);
    wr(8'h04, 32'h06000020);
    pcfr_peer_i.send(2, 3, 32'h3C3C0000);
    repeat (8) @(posedge clock);
    rd(8'h28, '1, 32'h00000005);
    wr(8'h04, 32'h06000000);
    rd(8'h28, '1, 32'h00000000);
    $display("receive done");
    close_out();
  end
endmodule
